// file: dv/data_memory_indirect_table_addr_tb.sv
// Self-checking bench for the data memory block.
`timescale 1ns/100ps
module data_memory_indirect_table_addr_tb;
  reg clk_in, nrst_in, mem_rd_in, mem_wr_in, bit_op_in, bit_set_in, alu_wr_in, pc_step_in;
  reg tbl_start_in, tbl_last_page_in;
  reg [7:0] mem_addr_in, mem_wdata_in, bit_mask_in, alu_result_in, tbl_dest_in;
  wire [7:0] mem_rdata_out, accumulator_out;
  wire [11:0] pc_out, tbl_addr_out;
  wire [14:0] prog_word_in;
  wire tbl_fetch_out;
  integer fails, checks, cyc;
  dmt_data_memory uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .mem_addr_in(mem_addr_in), .mem_rd_in(mem_rd_in),
    .mem_wr_in(mem_wr_in), .mem_wdata_in(mem_wdata_in), .bit_op_in(bit_op_in),
    .bit_mask_in(bit_mask_in), .bit_set_in(bit_set_in), .mem_rdata_out(mem_rdata_out),
    .alu_wr_in(alu_wr_in), .alu_result_in(alu_result_in), .accumulator_out(accumulator_out),
    .pc_step_in(pc_step_in), .pc_out(pc_out), .dummy_cycle_out(),
    .tbl_start_in(tbl_start_in), .tbl_last_page_in(tbl_last_page_in),
    .tbl_dest_in(tbl_dest_in), .tbl_addr_out(tbl_addr_out), .tbl_fetch_out(tbl_fetch_out),
    .prog_word_in(prog_word_in), .tbl_done_out());
  dmt_prog_mem_model pm (.fetch_in(tbl_fetch_out), .addr_in(tbl_addr_out), .word_out(prog_word_in));
  initial
  begin
    clk_in = 0;
    forever #2.5 clk_in = ~clk_in;
  end
  task step;
    @(posedge clk_in);
    #1;
  endtask
  task ck(input [14:0] e, input [14:0] s, input string n);
    checks = checks + 1;
    if (s !== e)
    begin
      fails = fails + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrm(input [7:0] ad, input [7:0] d);
    step;
    mem_addr_in = ad;
    mem_wdata_in = d;
    mem_wr_in = 1;
    step;
    mem_wr_in = 0;
  endtask
  task rdm(input [7:0] ad, input [7:0] e);
    step;
    mem_addr_in = ad;
    mem_rd_in = 1;
    step;
    mem_rd_in = 0;
    ck(e, mem_rdata_out, "rdata");
  endtask
  task bitop(input [7:0] ad, input [7:0] m, input s);
    step;
    mem_addr_in = ad;
    bit_mask_in = m;
    bit_set_in = s;
    bit_op_in = 1;
    step;
    bit_op_in = 0;
  endtask
  task tbl(input l, input [7:0] d);
    step;
    tbl_last_page_in = l;
    tbl_dest_in = d;
    tbl_start_in = 1;
    step;
    tbl_start_in = 0;
    repeat (2) step;
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      fails = fails + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    {mem_rd_in, mem_wr_in, bit_op_in, bit_set_in, alu_wr_in, pc_step_in} = 0;
    {tbl_start_in, tbl_last_page_in, mem_addr_in, mem_wdata_in} = 0;
    {bit_mask_in, alu_result_in, tbl_dest_in} = 0;
    {fails, checks, cyc} = 0;
    nrst_in = 0;
    repeat (20) step;
    nrst_in = 1;
    wrm(8'h40, 8'h11);
    wrm(8'hff, 8'h22);
    rdm(8'h40, 8'h11);
    rdm(8'hff, 8'h22);
    wrm(8'h20, 8'h55);
    rdm(8'h20, 8'h00);
    wrm(8'h01, 8'h41);
    rdm(8'h01, 8'h41);
    wrm(8'h00, 8'h5a);
    rdm(8'h41, 8'h5a);
    rdm(8'h00, 8'h5a);
    bitop(8'h41, 8'h80, 1);
    bitop(8'h41, 8'h02, 0);
    rdm(8'h41, 8'hd8);
    wrm(8'h01, 8'h00);
    wrm(8'h00, 8'h77);
    rdm(8'h00, 8'h00);
    step;
    alu_result_in = 8'h3c;
    alu_wr_in = 1;
    step;
    alu_wr_in = 0;
    step;
    ck(8'h3c, accumulator_out, "acc");
    rdm(8'h05, 8'h3c);
    pc_step_in = 1;
    repeat (256) step;
    pc_step_in = 0;
    wrm(8'h06, 8'h9a);
    step;
    ck(12'h19a, pc_out, "pc");
    wrm(8'h07, 8'h33);
    rdm(8'h07, 8'h33);
    tbl(0, 8'h42);
    rdm(8'h08, 8'h51);
    rdm(8'h42, 8'h33);
    tbl(1, 8'h43);
    rdm(8'h08, 8'h5f);
    rdm(8'h43, 8'h33);
    wrm(8'h08, 8'h00);
    rdm(8'h08, 8'h5f);
    bitop(8'h08, 8'h01, 0);
    rdm(8'h08, 8'h5f);
    tally_and_finish;
  end
endmodule // data_memory_indirect_table_addr_tb

// file: dv/dmt_data_memory_chk.sv
// Port assertions for the data memory block.
`timescale 1ns/100ps
module dmt_data_memory_chk (
  input wire        clk_in,
  input wire        nrst_in,
  input wire [7:0]  mem_addr_in,
  input wire        mem_rd_in,
  input wire        mem_wr_in,
  input wire [7:0]  mem_wdata_in,
  input wire        alu_wr_in,
  input wire [7:0]  alu_result_in,
  input wire        tbl_start_in,
  input wire        tbl_last_page_in,
  input wire [7:0]  mem_rdata_out,
  input wire [7:0]  accumulator_out,
  input wire [11:0] pc_out,
  input wire        dummy_cycle_out,
  input wire [11:0] tbl_addr_out,
  input wire        tbl_fetch_out,
  input wire        tbl_done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_start;
    tbl_start_in && !tbl_fetch_out;
  endsequence
  sequence s_fetch_done;
    tbl_fetch_out ##1 tbl_done_out;
  endsequence
  chk_table_two_cycles:
    assert property (s_start |=> s_fetch_done) else $error("table timing");
  chk_done_one_cycle:
    assert property (tbl_done_out |=> !tbl_done_out) else $error("done width");
  chk_last_page_ones:
    assert property (s_start ##0 tbl_last_page_in |=> tbl_addr_out[11:8] == 4'hf)
    else $error("last page");
  chk_current_page_bits:
    assert property (s_start ##0 !tbl_last_page_in |=> tbl_addr_out[11:8] == pc_out[11:8])
    else $error("current page");
  chk_pcl_dummy:
    assert property (mem_wr_in && mem_addr_in == 8'h06 |=> dummy_cycle_out) else $error("dummy");
  chk_pcl_jump:
    assert property (mem_wr_in && mem_addr_in == 8'h06 |-> ##2
      pc_out[7:0] == $past(mem_wdata_in, 2)) else $error("pcl jump");
  chk_unused_zero:
    assert property (mem_rd_in && mem_addr_in > 8'h08 && mem_addr_in < 8'h40 |=>
      mem_rdata_out == 8'h00) else $error("unused read");
  chk_alu_to_acc:
    assert property (alu_wr_in |-> ##2 accumulator_out == $past(alu_result_in, 2))
    else $error("acc load");
endmodule // dmt_data_memory_chk
bind dmt_data_memory dmt_data_memory_chk chk (
  .clk_in(clk_in), .nrst_in(nrst_in), .mem_addr_in(mem_addr_in), .mem_rd_in(mem_rd_in),
  .mem_wr_in(mem_wr_in), .mem_wdata_in(mem_wdata_in), .alu_wr_in(alu_wr_in),
  .alu_result_in(alu_result_in), .tbl_start_in(tbl_start_in),
  .tbl_last_page_in(tbl_last_page_in), .mem_rdata_out(mem_rdata_out),
  .accumulator_out(accumulator_out), .pc_out(pc_out), .dummy_cycle_out(dummy_cycle_out),
  .tbl_addr_out(tbl_addr_out), .tbl_fetch_out(tbl_fetch_out), .tbl_done_out(tbl_done_out));

// file: dv/dmt_prog_mem_model.sv
// Program memory answering table fetches.
`timescale 1ns/100ps
module dmt_prog_mem_model (
  input  wire        fetch_in,
  input  wire [11:0] addr_in,
  output wire [14:0] word_out
);
  // Outside a fetch the word is inverted so stale data never looks valid.
  assign word_out = fetch_in ? {3'h5, addr_in} : ~{3'h5, addr_in};
endmodule // dmt_prog_mem_model

// file: verilog/dmt_data_memory.v
// Data memory space with indirect port, accumulator, program counter low and table read.
`timescale 1ns/100ps
`include "dmt_regs.vh"

module dmt_data_memory
#(
  parameter TBL_WIDTH  = 12,
  parameter GP_LEN     = 192,
  parameter SMALL_RAM  = 0,
  parameter [7:0] PROT_MASK_TABLE_HIGH_BYTE = 8'hff
)
(
  // Clock and reset
  input  wire        clk_in,
  input  wire        nrst_in,
  // Data memory access from the core
  input  wire [7:0]  mem_addr_in,
  input  wire        mem_rd_in,
  input  wire        mem_wr_in,
  input  wire [7:0]  mem_wdata_in,
  input  wire        bit_op_in,
  input  wire [7:0]  bit_mask_in,
  input  wire        bit_set_in,
  output reg  [7:0]  mem_rdata_out,
  // Accumulator load from the ALU
  input  wire        alu_wr_in,
  input  wire [7:0]  alu_result_in,
  output reg  [7:0]  accumulator_out,
  // Program counter
  input  wire        pc_step_in,
  output reg  [11:0] pc_out,
  output reg         dummy_cycle_out,
  // Table read
  input  wire        tbl_start_in,
  input  wire        tbl_last_page_in,
  input  wire [7:0]  tbl_dest_in,
  output reg  [11:0] tbl_addr_out,
  output reg         tbl_fetch_out,
  input  wire [14:0] prog_word_in,
  output reg         tbl_done_out
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_FETCH = 1'b1;

  reg  [7:0]  ram [0:255];
  reg  [7:0]  mp_reg;
  reg  [7:0]  acc_reg;
  reg  [7:0]  tblp_reg;
  reg  [7:0]  table_high_byte_reg;
  reg  [11:0] pc_reg;
  reg         state_reg;
  reg  [7:0]  dest_reg;
  reg  [11:0] taddr_next;
  reg  [7:0]  eff_addr;
  reg  [7:0]  rd_val;
  reg  [7:0]  cur_val;
  reg  [7:0]  wr_val;
  reg         gp_hit;
  reg  [8:0]  gp_off;
  // Write and table decode strobes.
  reg         wr_any;
  reg         wr_mp;
  reg         wr_acc;
  reg         wr_pcl;
  reg         wr_tblp;
  reg         wr_ram;
  reg         tbl_end;
  reg         tbl_mp;
  reg         tbl_acc;
  reg         tbl_tblp;
  reg         tbl_ram;
  reg  [8:0]  dest_off;
  wire [11:0] width_mask;

  assign width_mask = (12'hfff >> (12 - TBL_WIDTH));

  // Indirect port redirects through the pointer with no extra cycle.
  always @*
  begin
    if (mem_addr_in == `DMT_ADDR_IND)
      eff_addr = mp_reg;
    else
      eff_addr = mem_addr_in;
    gp_off = {1'b0, eff_addr} - {1'b0, `DMT_GP_START};
    gp_hit = (eff_addr >= `DMT_GP_START) && (gp_off < GP_LEN);
  end

  // Unused special addresses and the port seen through itself read as zero.
  always @*
  begin
    if (eff_addr == `DMT_ADDR_IND)
      rd_val = `DMT_RST_BYTE;
    else if (eff_addr == `DMT_ADDR_MP)
      rd_val = SMALL_RAM ? (mp_reg | 8'h80) : mp_reg;
    else if (eff_addr == `DMT_ADDR_ACC)
      rd_val = acc_reg;
    else if (eff_addr == `DMT_ADDR_PCL)
      rd_val = pc_reg[7:0];
    else if (eff_addr == `DMT_ADDR_TBLP)
      rd_val = tblp_reg;
    else if (eff_addr == `DMT_ADDR_TABLE_HIGH_BYTE)
      rd_val = table_high_byte_reg;
    else if (gp_hit)
      rd_val = ram[eff_addr];
    else
      rd_val = `DMT_RST_BYTE;
  end

  // Bit operations read, modify and write one byte.
  always @*
  begin
    cur_val = rd_val;
    if (bit_op_in)
      wr_val = bit_set_in ? (cur_val | bit_mask_in) : (cur_val & ~bit_mask_in);
    else
      wr_val = mem_wdata_in;
  end

  always @*
  begin
    if (tbl_last_page_in)
      taddr_next = {4'hf, tblp_reg} & width_mask;
    else
      taddr_next = {pc_reg[`DMT_PAGE_MSB:`DMT_PAGE_LSB], tblp_reg} & width_mask;
  end

  // The indirect port never stores, and the table high byte has no write path.
  always @*
  begin
    wr_any  = (mem_wr_in || bit_op_in) && (eff_addr != `DMT_ADDR_IND);
    wr_mp   = wr_any && (eff_addr == `DMT_ADDR_MP);
    wr_acc  = wr_any && (eff_addr == `DMT_ADDR_ACC);
    wr_pcl  = wr_any && (eff_addr == `DMT_ADDR_PCL);
    wr_tblp = wr_any && (eff_addr == `DMT_ADDR_TBLP);
    wr_ram  = wr_any && gp_hit;
  end

  // A table read lands its low byte in the destination during the fetch state.
  always @*
  begin
    tbl_end  = (state_reg == ST_FETCH);
    dest_off = {1'b0, dest_reg} - {1'b0, `DMT_GP_START};
    tbl_mp   = tbl_end && (dest_reg == `DMT_ADDR_MP);
    tbl_acc  = tbl_end && (dest_reg == `DMT_ADDR_ACC);
    tbl_tblp = tbl_end && (dest_reg == `DMT_ADDR_TBLP);
    tbl_ram  = tbl_end && (dest_reg >= `DMT_GP_START) && (dest_off < GP_LEN);
  end

  // A table read into the pointer wins over a bus write in the same cycle.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      mp_reg <= `DMT_RST_BYTE;
    else if (tbl_mp)
      mp_reg <= SMALL_RAM ? {1'b0, prog_word_in[6:0]} : prog_word_in[7:0];
    else if (wr_mp)
      mp_reg <= SMALL_RAM ? {1'b0, wr_val[6:0]} : wr_val;
  end

  // A table result, then the ALU result, take priority over a bus write.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      acc_reg <= `DMT_RST_BYTE;
    else if (tbl_acc)
      acc_reg <= prog_word_in[7:0];
    else if (alu_wr_in)
      acc_reg <= alu_result_in;
    else if (wr_acc)
      acc_reg <= wr_val;
  end

  // A table read into the table pointer wins over a bus write in the same cycle.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      tblp_reg <= `DMT_RST_BYTE;
    else if (tbl_tblp)
      tblp_reg <= prog_word_in[7:0];
    else if (wr_tblp)
      tblp_reg <= wr_val;
  end

  // A low-byte write keeps the page bits, so the jump stays inside the page.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      pc_reg <= `DMT_RST_PC;
    else if (wr_pcl)
      pc_reg <= {pc_reg[`DMT_PAGE_MSB:`DMT_PAGE_LSB], wr_val};
    else if (pc_step_in)
      pc_reg <= (pc_reg + 12'h001) & width_mask;
  end

  // The core stalls one cycle while the new program counter takes effect.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      dummy_cycle_out <= 1'b0;
    else
      dummy_cycle_out <= wr_pcl;
  end

  // General purpose storage has no reset; a bus write and a table result may land together.
  always @(posedge clk_in)
  begin
    if (wr_ram)
      ram[eff_addr] <= wr_val;
    if (tbl_ram)
      ram[dest_reg] <= prog_word_in[7:0];
  end

  // Table read sequencer: start, one fetch cycle, then completion.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg     <= ST_IDLE;
      dest_reg      <= `DMT_RST_BYTE;
      tbl_addr_out  <= `DMT_RST_PC;
      tbl_fetch_out <= 1'b0;
      tbl_done_out  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          tbl_done_out <= 1'b0;
          if (tbl_start_in)
          begin
            tbl_addr_out  <= taddr_next;
            tbl_fetch_out <= 1'b1;
            dest_reg      <= tbl_dest_in;
            state_reg     <= ST_FETCH;
          end
        end
        ST_FETCH:
        begin
          tbl_fetch_out <= 1'b0;
          tbl_done_out  <= 1'b1;
          state_reg     <= ST_IDLE;
        end
        default:
        begin
          tbl_fetch_out <= 1'b0;
          tbl_done_out  <= 1'b0;
          state_reg     <= ST_IDLE;
        end
      endcase
    end
  end

  // Only a table read loads the high byte; bit seven lies beyond the 15-bit word.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
      table_high_byte_reg <= `DMT_RST_BYTE;
    else if (tbl_end)
      table_high_byte_reg <= {1'b0, prog_word_in[14:8]} & PROT_MASK_TABLE_HIGH_BYTE;
  end

  // Registered copies keep every output straight from a flip-flop.
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      mem_rdata_out   <= `DMT_RST_BYTE;
      accumulator_out <= `DMT_RST_BYTE;
      pc_out          <= `DMT_RST_PC;
    end
    else
    begin
      if (mem_rd_in)
        mem_rdata_out <= rd_val;
      accumulator_out <= acc_reg;
      pc_out          <= pc_reg;
    end
  end

endmodule // dmt_data_memory

// file: verilog/dmt_regs.vh
// Data memory map, field positions and variant constants.
`ifndef DMT_REGS_VH
`define DMT_REGS_VH
`define DMT_ADDR_IND       8'h00
`define DMT_ADDR_MP        8'h01
`define DMT_ADDR_ACC       8'h05
`define DMT_ADDR_PCL       8'h06
`define DMT_ADDR_TBLP      8'h07
`define DMT_ADDR_TABLE_HIGH_BYTE      8'h08
`define DMT_GP_START       8'h40
`define DMT_GP_LEN_DEF     9'h0c0
`define DMT_PAGE_MSB       11
`define DMT_PAGE_LSB       8
`define DMT_PTR_TOP_BIT    7
`define DMT_PC_WIDTH       12
`define DMT_WORD_WIDTH     15
`define DMT_RST_BYTE       8'h00
`define DMT_RST_PC         12'h000
`endif
